// ---- shared/icf_pkg.sv ----
// Purpose : Shared constants for the capture flag block of channels B, C and D
// Assumes : APB slave with 32-bit data, one aligned word per register
// Notes   : Flag, enable and edge fields share bit positions 6, 5 and 4
`default_nettype none

package icf_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned REG_W   = 8;
  localparam int unsigned NUM_CH  = 3;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_B  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_C  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_D  = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned BIT_CH_B      = 6;
  localparam int unsigned BIT_CH_C      = 5;
  localparam int unsigned BIT_CH_D      = 4;
  localparam int unsigned BIT_BUFFER_A  = 3;
  localparam int unsigned BIT_BUFFER_B  = 2;

  // Channel index within three-bit vectors
  localparam int unsigned CH_B = 2;
  localparam int unsigned CH_C = 1;
  localparam int unsigned CH_D = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [NUM_CH-1:0] RST_FLAGS   = 3'h0;
  localparam logic [NUM_CH-1:0] RST_EDGES   = 3'h0;
  localparam logic [NUM_CH-1:0] RST_ENABLES = 3'h0;
  localparam logic              RST_BUFFER  = 1'h0;
  localparam logic [CNT_W-1:0]  RST_CAPTURE = 16'h0000;

  // ****************************************************************
  // Bus answer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ICF_BUS_IDLE  = 2'b00,
    ICF_BUS_WAIT  = 2'b01,
    ICF_BUS_READY = 2'b10
  } icf_bus_state_t;

endpackage

`default_nettype wire

// ---- shared/icf_edge_if.sv ----
// Purpose : Carries pin levels, edge choices and detected events
// Assumes : Single clock domain
// Notes   : Bit order of every vector is B, C, D from high to low
`default_nettype none

interface icf_edge_if;
  import icf_pkg::*;

  logic [NUM_CH-1:0] pin_level;
  logic [NUM_CH-1:0] edge_rise;
  logic [NUM_CH-1:0] event_hit;

  modport det (
    input  pin_level,
    input  edge_rise,
    output event_hit
  );

  modport use_side (
    output pin_level,
    output edge_rise,
    input  event_hit
  );

endinterface

`default_nettype wire

// ---- logic/icf_edge_detect.sv ----
// Purpose : Finds the selected edge on each capture pin
// Assumes : Pin levels synchronous to the clock
// Notes   : Event is a one-cycle pulse in the cycle the new level is seen
`default_nettype none

module icf_edge_detect
  import icf_pkg::*;
(
  // Clock and reset
  input  wire logic  i_clk_sys,
  input  wire logic  i_rst,
  // Pins and events
  icf_edge_if.det    edge_bus
);

  logic [NUM_CH-1:0] level_prev_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      level_prev_reg <= RST_EDGES;
    end else begin
      level_prev_reg <= edge_bus.pin_level;
    end
  end

  // ****************************************************************
  // Per-channel polarity choice
  // ****************************************************************
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    assign edge_bus.event_hit[ch] = edge_bus.edge_rise[ch] ?
                                    (edge_bus.pin_level[ch] & ~level_prev_reg[ch]) :
                                    (~edge_bus.pin_level[ch] & level_prev_reg[ch]);
  end

endmodule

`default_nettype wire

// ---- logic/icf_capture_top.sv ----
// Purpose : Capture flags and registers of channels B, C and D over APB
// Assumes : Free-running count supplied by the timer, pins synchronous
// Notes   : Flags clear by a read seeing one followed by a write of zero
//
// Implementation choices: the address map and the APB slave port.
`default_nettype none

module icf_capture_top
  import icf_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [DATA_W-1:0] i_pwdata,
  output logic      [DATA_W-1:0] o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Timer and capture pins
  input  wire logic [CNT_W-1:0]  i_free_running_count,
  input  wire logic              i_capture_pin_b,
  input  wire logic              i_capture_pin_c,
  input  wire logic              i_capture_pin_d,
  // Interrupts
  output logic                   o_irq,
  output logic      [NUM_CH-1:0] o_capture_irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  icf_bus_state_t    bus_state_reg;
  icf_bus_state_t    bus_state_next;
  logic [NUM_CH-1:0] flag_reg;
  logic [NUM_CH-1:0] flag_next;
  logic [NUM_CH-1:0] armed_reg;
  logic [NUM_CH-1:0] edge_select_reg;
  logic [NUM_CH-1:0] irq_enable_reg;
  logic [NUM_CH-1:0] irq_enable_next;
  logic              buffer_enable_a_reg;
  logic              buffer_enable_b_reg;
  logic [CNT_W-1:0]  capture_reg_b;
  logic [CNT_W-1:0]  capture_reg_c;
  logic [CNT_W-1:0]  capture_reg_d;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              pslverr_reg;
  logic              addr_hit;
  logic              irq_reg;
  logic [NUM_CH-1:0] capture_irq_reg;
  logic [NUM_CH-1:0] capture_irq_next;

  // Bus decode
  logic              bus_done;
  logic              wr_done;
  logic              rd_done;
  logic              wr_status;
  logic              rd_status;
  logic [NUM_CH-1:0] wr_flag_bits;
  logic [NUM_CH-1:0] clear_req;
  logic [NUM_CH-1:0] cap_event;

  icf_edge_if edge_bus ();

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  assign edge_bus.pin_level = {i_capture_pin_b, i_capture_pin_c, i_capture_pin_d};
  assign edge_bus.edge_rise = edge_select_reg;
  assign cap_event          = edge_bus.event_hit;

  icf_edge_detect u_edge_detect (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .edge_bus  (edge_bus.det)
  );

  // ****************************************************************
  // APB handshake
  // ****************************************************************
  always_comb begin
    bus_state_next = bus_state_reg;
    unique case (bus_state_reg)
      ICF_BUS_IDLE: begin
        if (i_psel && !i_penable) begin
          bus_state_next = ICF_BUS_WAIT;
        end
      end
      ICF_BUS_WAIT: begin
        if (i_psel && i_penable) begin
          bus_state_next = ICF_BUS_READY;
        end else if (!i_psel) begin
          bus_state_next = ICF_BUS_IDLE;
        end
      end
      ICF_BUS_READY: begin
        bus_state_next = ICF_BUS_IDLE;
      end
      default: begin
        bus_state_next = ICF_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bus_state_reg <= ICF_BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  assign bus_done = (bus_state_reg == ICF_BUS_READY) && i_psel && i_penable;
  assign wr_done  = bus_done && i_pwrite && !pslverr_reg;
  assign rd_done  = bus_done && !i_pwrite && !pslverr_reg;
  assign wr_status = wr_done && (i_paddr == OFS_STATUS);
  assign rd_status = rd_done && (i_paddr == OFS_STATUS);
  assign wr_flag_bits = {i_pwdata[BIT_CH_B], i_pwdata[BIT_CH_C], i_pwdata[BIT_CH_D]};

  // ****************************************************************
  // Read data and address check
  // ****************************************************************
  always_comb begin
    rdata_next = '0;
    addr_hit   = 1'b1;
    unique case (i_paddr)
      OFS_STATUS: begin
        rdata_next[BIT_CH_B] = flag_reg[CH_B];
        rdata_next[BIT_CH_C] = flag_reg[CH_C];
        rdata_next[BIT_CH_D] = flag_reg[CH_D];
      end
      OFS_CONTROL: begin
        rdata_next[BIT_CH_B]     = edge_select_reg[CH_B];
        rdata_next[BIT_CH_C]     = edge_select_reg[CH_C];
        rdata_next[BIT_CH_D]     = edge_select_reg[CH_D];
        rdata_next[BIT_BUFFER_A] = buffer_enable_a_reg;
        rdata_next[BIT_BUFFER_B] = buffer_enable_b_reg;
      end
      OFS_IRQ_ENABLE: begin
        rdata_next[BIT_CH_B] = irq_enable_reg[CH_B];
        rdata_next[BIT_CH_C] = irq_enable_reg[CH_C];
        rdata_next[BIT_CH_D] = irq_enable_reg[CH_D];
      end
      OFS_CAPTURE_B: rdata_next[CNT_W-1:0] = capture_reg_b;
      OFS_CAPTURE_C: rdata_next[CNT_W-1:0] = capture_reg_c;
      OFS_CAPTURE_D: rdata_next[CNT_W-1:0] = capture_reg_d;
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (bus_state_reg == ICF_BUS_WAIT && i_psel && i_penable) begin
      prdata_reg  <= i_pwrite ? '0 : rdata_next;
      pslverr_reg <= !addr_hit;
    end else if (bus_state_reg == ICF_BUS_READY) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Control and enable registers
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      edge_select_reg     <= RST_EDGES;
      buffer_enable_a_reg <= RST_BUFFER;
      buffer_enable_b_reg <= RST_BUFFER;
    end else if (wr_done && i_paddr == OFS_CONTROL) begin
      edge_select_reg     <= wr_flag_bits;
      buffer_enable_a_reg <= i_pwdata[BIT_BUFFER_A];
      buffer_enable_b_reg <= i_pwdata[BIT_BUFFER_B];
    end
  end

  // Next enable feeds the requests, so a request never outlives its enable
  always_comb begin
    irq_enable_next = irq_enable_reg;
    if (wr_done && i_paddr == OFS_IRQ_ENABLE) begin
      irq_enable_next = wr_flag_bits;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      irq_enable_reg <= RST_ENABLES;
    end else begin
      irq_enable_reg <= irq_enable_next;
    end
  end

  // ****************************************************************
  // Flag clearing: read as one, then write zero
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      armed_reg <= RST_FLAGS;
    end else if (rd_status) begin
      armed_reg <= {prdata_reg[BIT_CH_B], prdata_reg[BIT_CH_C], prdata_reg[BIT_CH_D]};
    end else if (wr_status) begin
      armed_reg <= RST_FLAGS;
    end
  end

  assign clear_req = wr_status ? (armed_reg & ~wr_flag_bits) : RST_FLAGS;

  // ****************************************************************
  // Capture flags
  // ****************************************************************
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_flag
    assign flag_next[ch] = cap_event[ch] |
                           (flag_reg[ch] & ~clear_req[ch]);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      flag_reg <= RST_FLAGS;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ****************************************************************
  // Capture registers
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      capture_reg_b <= RST_CAPTURE;
    end else if (cap_event[CH_B]) begin
      capture_reg_b <= i_free_running_count;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      capture_reg_c <= RST_CAPTURE;
    end else if (cap_event[CH_C] && !buffer_enable_a_reg) begin
      capture_reg_c <= i_free_running_count;
    end
  end

  // In buffer mode D takes the old B capture on a B edge and ignores every D edge
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      capture_reg_d <= RST_CAPTURE;
    end else if (buffer_enable_b_reg) begin
      if (cap_event[CH_B]) begin
        capture_reg_d <= capture_reg_b;
      end
    end else if (cap_event[CH_D]) begin
      capture_reg_d <= i_free_running_count;
    end
  end

  // ****************************************************************
  // Interrupt requests
  // ****************************************************************
  assign capture_irq_next = flag_next & irq_enable_next;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      capture_irq_reg <= RST_FLAGS;
      irq_reg         <= 1'b0;
    end else begin
      capture_irq_reg <= capture_irq_next;
      irq_reg         <= |capture_irq_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_prdata      = prdata_reg;
  assign o_pready      = (bus_state_reg == ICF_BUS_READY);
  assign o_pslverr     = pslverr_reg;
  assign o_irq         = irq_reg;
  assign o_capture_irq = capture_irq_reg;

endmodule

`default_nettype wire

// ---- test/icf_pin_model.sv ----
// Purpose : Outside world of the capture block: timer count and pins
// Assumes : Pins change just after a rising edge, synchronous levels
// Notes   : Count steps by three so each capture value is distinct
`default_nettype none

module icf_pin_model
  import icf_pkg::*;
(
  // Clock
  input  wire logic              i_clk_sys,
  // Count and pins
  output logic      [CNT_W-1:0]  o_count,
  output logic      [NUM_CH-1:0] o_pins
);
  initial begin
    o_count = 16'h1234;
    o_pins = 3'h0;
  end

  always @(posedge i_clk_sys) begin
    o_count <= o_count + 16'h0003;
  end

  // New level after an edge; returns count seen with that level
  task automatic drive(input int ch, input logic lvl, output logic [CNT_W-1:0] cnt);
    @(posedge i_clk_sys);
    o_pins[ch] <= lvl;
    @(posedge i_clk_sys);
    cnt = o_count;
  endtask
endmodule

`default_nettype wire

// ---- test/icf_properties.sv ----
// Purpose : Port checks for the capture flag block
// Assumes : One clock, synchronous active-high reset
// Notes   : Bound to the top module below
`default_nettype none

module icf_properties
  import icf_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // APB
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [DATA_W-1:0] i_pwdata,
  input  wire logic [DATA_W-1:0] o_prdata,
  input  wire logic              o_pready,
  input  wire logic              o_pslverr,
  // Count and pins
  input  wire logic [CNT_W-1:0]  i_free_running_count,
  input  wire logic              i_capture_pin_b,
  input  wire logic              i_capture_pin_c,
  input  wire logic              i_capture_pin_d,
  // Interrupts
  input  wire logic              o_irq,
  input  wire logic [NUM_CH-1:0] o_capture_irq
);
  logic wr_acc;

  assign wr_acc = i_psel & i_penable & i_pwrite;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  pready_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready missing after access");
  pready_once_a: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property (i_psel && i_penable && !o_pready && i_paddr > 8'h14
    |=> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer");
  irq_sum_a: assert property (o_irq == |o_capture_irq)
    else $error("irq not the sum of channel requests");
  clear_b_a: assert property ($fell(o_capture_irq[CH_B]) |-> $past(wr_acc))
    else $error("request b dropped without write");
  clear_c_a: assert property ($fell(o_capture_irq[CH_C]) |-> $past(wr_acc))
    else $error("request c dropped without write");
  clear_d_a: assert property ($fell(o_capture_irq[CH_D]) |-> $past(wr_acc))
    else $error("request d dropped without write");
  rise_c_a: assert property ($rose(o_capture_irq[CH_C]) |->
    $past(i_capture_pin_c) != $past(i_capture_pin_c, 2) || $past(wr_acc))
    else $error("request c without pin edge or write");
  rise_d_a: assert property ($rose(o_capture_irq[CH_D]) |->
    $past(i_capture_pin_d) != $past(i_capture_pin_d, 2) || $past(wr_acc))
    else $error("request d without pin edge or write");
  reset_quiet_a: assert property (disable iff (1'b0) i_rst |=> !o_irq && !o_pready)
    else $error("outputs active after reset");
endmodule

bind icf_capture_top icf_properties chk (.*);

`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose : Self-checking bench for the capture flag block
// Assumes : APB answers after one wait state, pins via the pin model
// Notes   : Each scenario is one task that judges its own results
`default_nettype none

module tb_top
  import icf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              i_clk_sys = 1'b0;
  logic              i_rst = 1'b1;
  logic              i_psel = 1'b0;
  logic              i_penable = 1'b0;
  logic              i_pwrite = 1'b0;
  logic [ADDR_W-1:0] i_paddr = '0;
  logic [DATA_W-1:0] i_pwdata = '0;
  logic [DATA_W-1:0] o_prdata;
  logic              o_pready;
  logic              o_pslverr;
  logic              o_irq;
  logic [NUM_CH-1:0] o_capture_irq;
  logic [NUM_CH-1:0] pins;
  logic [CNT_W-1:0]  i_free_running_count;
  logic [DATA_W-1:0] rdv;
  logic              err;
  logic [CNT_W-1:0]  c1;
  logic [CNT_W-1:0]  c2;
  int                n_mismatch = 0;
  int                n_checks = 0;
  int                cycles = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  icf_pin_model pm (.i_clk_sys(i_clk_sys), .o_count(i_free_running_count), .o_pins(pins));

  icf_capture_top uut (
    .i_clk_sys            (i_clk_sys),
    .i_rst                (i_rst),
    .i_psel               (i_psel),
    .i_penable            (i_penable),
    .i_pwrite             (i_pwrite),
    .i_paddr              (i_paddr),
    .i_pwdata             (i_pwdata),
    .o_prdata             (o_prdata),
    .o_pready             (o_pready),
    .o_pslverr            (o_pslverr),
    .i_free_running_count (i_free_running_count),
    .i_capture_pin_b      (pins[CH_B]),
    .i_capture_pin_c      (pins[CH_C]),
    .i_capture_pin_d      (pins[CH_D]),
    .o_irq                (o_irq),
    .o_capture_irq        (o_capture_irq)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do @(posedge i_clk_sys); while (o_pready !== 1'b1);
    rdv = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [ADDR_W-1:0] ofs [6] = '{OFS_STATUS, OFS_CONTROL, OFS_IRQ_ENABLE,
                                   OFS_CAPTURE_B, OFS_CAPTURE_C, OFS_CAPTURE_D};
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], '0);
      chk("reset value", rdv, '0);
    end
    apb(1'b1, 8'h40, 32'hffffffff);
    chk("unmapped error", {31'h0, err}, 32'h1);
    $display("reset test done");
  endtask

  task automatic t_cap_b();
    apb(1'b1, OFS_CONTROL, 32'h40);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h40);
    pm.drive(CH_B, 1'b1, c1);
    @(posedge i_clk_sys);
    chk("irq b", {o_irq, o_capture_irq}, 32'hc);
    apb(1'b0, OFS_CAPTURE_B, '0);
    chk("capture b", rdv, {16'h0, c1});
    apb(1'b1, OFS_STATUS, '0);
    apb(1'b0, OFS_STATUS, '0);
    chk("flag b unread write", rdv, 32'h40);
    apb(1'b1, OFS_STATUS, 32'h40);
    apb(1'b0, OFS_STATUS, '0);
    chk("flag b write one", rdv, 32'h40);
    apb(1'b1, OFS_STATUS, '0);
    apb(1'b0, OFS_STATUS, '0);
    chk("flag b cleared", rdv, '0);
    pm.drive(CH_B, 1'b0, c2);
    apb(1'b0, OFS_STATUS, '0);
    chk("falling b ignored", rdv, '0);
    $display("capture b test done");
  endtask

  task automatic t_buf_b();
    apb(1'b1, OFS_CONTROL, 32'h54);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h10);
    pm.drive(CH_B, 1'b1, c1);
    pm.drive(CH_B, 1'b0, c2);
    pm.drive(CH_B, 1'b1, c2);
    apb(1'b0, OFS_CAPTURE_B, '0);
    chk("capture b new", rdv, {16'h0, c2});
    apb(1'b0, OFS_CAPTURE_D, '0);
    chk("capture d old b", rdv, {16'h0, c1});
    pm.drive(CH_D, 1'b1, c2);
    @(posedge i_clk_sys);
    chk("irq d", {o_irq, o_capture_irq}, 32'h9);
    apb(1'b0, OFS_CAPTURE_D, '0);
    chk("capture d kept", rdv, {16'h0, c1});
    apb(1'b0, OFS_STATUS, '0);
    chk("flags b d", rdv, 32'h50);
    apb(1'b1, OFS_STATUS, 32'h40);
    apb(1'b0, OFS_STATUS, '0);
    chk("flag d cleared", rdv, 32'h40);
    apb(1'b1, OFS_STATUS, '0);
    $display("buffer b test done");
  endtask

  task automatic t_chan_c();
    apb(1'b1, OFS_CONTROL, '0);
    apb(1'b1, OFS_IRQ_ENABLE, '0);
    pm.drive(CH_D, 1'b0, c2);
    apb(1'b0, OFS_CAPTURE_D, '0);
    chk("capture d", rdv, {16'h0, c2});
    pm.drive(CH_C, 1'b1, c2);
    pm.drive(CH_C, 1'b0, c1);
    apb(1'b0, OFS_CAPTURE_C, '0);
    chk("capture c", rdv, {16'h0, c1});
    apb(1'b0, OFS_STATUS, '0);
    chk("flags c d falling", rdv, 32'h30);
    chk("irq c masked", {o_irq, o_capture_irq}, '0);
    apb(1'b1, OFS_STATUS, '0);
    apb(1'b1, OFS_CONTROL, 32'h08);
    pm.drive(CH_C, 1'b1, c2);
    pm.drive(CH_C, 1'b0, c2);
    apb(1'b0, OFS_CAPTURE_C, '0);
    chk("capture c frozen", rdv, {16'h0, c1});
    apb(1'b1, OFS_IRQ_ENABLE, 32'h20);
    chk("irq c", {o_irq, o_capture_irq}, 32'ha);
    apb(1'b0, OFS_STATUS, '0);
    chk("flag c buffer", rdv, 32'h20);
    apb(1'b1, OFS_STATUS, '0);
    apb(1'b0, OFS_STATUS, '0);
    chk("flag c cleared", rdv, '0);
    $display("channel c test done");
  endtask

  // ****************************************************************
  // Sequence and timeout
  // ****************************************************************
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    t_reset();
    t_cap_b();
    t_buf_b();
    t_chan_c();
    stop_test();
  end
endmodule

`default_nettype wire
